// ---- design/pldr_pkg.sv ----
/*
 * Constants, register map and types for the dual-register output cell block.
 * Assumes a single 200 MHz clock and an APB slave with 32-bit data.
 */
package pldr_pkg;

  // ****************************************************************
  // Structure
  // ****************************************************************
  localparam int NUM_CELLS = 10;
  localparam int NUM_FF    = 20;
  localparam int NUM_IN    = 11;
  localparam int ARR_W     = 42;
  localparam int SEL_W     = 6;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;
  localparam int ADDR_LSB  = 2;

  // Array input positions: clock pin, input pins, I/O pins, feedbacks
  localparam int ARR_CLK   = 0;
  localparam int ARR_IN_LO = 1;
  localparam int ARR_IO_LO = 12;
  localparam int ARR_FB_LO = 22;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_PINS    = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_FF_BASE = 12'h040;
  localparam logic [ADDR_W-1:0] OFS_FF_END  = 12'h090;
  localparam logic [ADDR_W-1:0] OFS_IO_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_IO_END  = 12'h128;
  localparam int FF_IDX_MSB = 6;
  localparam int IO_IDX_MSB = 5;

  // Control fields
  localparam int CTRL_LEGACY_BIT = 0;
  localparam int CTRL_SECURE_BIT = 1;
  localparam int CTRL_PSEL_LSB   = 8;
  localparam int CTRL_PINV_BIT   = 14;

  // Flip-flop configuration fields
  localparam int FF_DSEL_LSB   = 0;
  localparam int FF_DINV_BIT   = 6;
  localparam int FF_CSEL_LSB   = 8;
  localparam int FF_CINV_BIT   = 14;
  localparam int FF_RSEL_LSB   = 16;
  localparam int FF_RINV_BIT   = 22;
  localparam int FF_TMODE_BIT  = 24;
  localparam int FF_PINCLK_BIT = 25;

  // I/O configuration fields
  localparam int IO_OSEL_LSB = 0;
  localparam int IO_OINV_BIT = 6;
  localparam int IO_POL_BIT  = 8;

  // Writable masks and reset values; a select of 42 or more reads as low
  localparam logic [DATA_W-1:0] CTRL_MASK   = 32'h0000_7F03;
  localparam logic [DATA_W-1:0] FF_MASK     = 32'h037F_7F7F;
  localparam logic [DATA_W-1:0] IO_MASK     = 32'h0000_017F;
  localparam logic [DATA_W-1:0] CTRL_RST    = 32'h0000_3F00;
  localparam logic [DATA_W-1:0] FF_CFG_RST  = 32'h003F_3F00;
  localparam logic [DATA_W-1:0] IO_CFG_RST  = 32'h0000_003F;
  localparam logic [DATA_W-1:0] FUSED_READ  = 32'hFFFF_FFFF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_PR_NS       = 1000;
  // Longest time: round down
  localparam int PUR_CYCLES    = (T_PR_NS * 1000) / CLK_PERIOD_PS;
  localparam int PUR_W         = 8;

  typedef enum logic [0:0] {
    POR_HOLD = 1'b0,
    POR_RUN  = 1'b1
  } pldr_por_t;

endpackage

// ---- design/pldr_term.sv ----
/*
 * One single-literal product term: picks one array input and may invert it.
 * Assumes the array vector is on the pclk domain.
 */
`timescale 1ns/1ps
module pldr_term (
  input  wire logic [pldr_pkg::ARR_W-1:0] arr,
  input  wire logic [pldr_pkg::SEL_W-1:0] sel,
  input  wire logic                       inv,
  output logic                            term
);

  // Out-of-range selects give a constant low, so inv alone gives high
  always_comb begin
    term = inv;
    if (int'(sel) < pldr_pkg::ARR_W) begin
      term = arr[sel] ^ inv;
    end
  end

endmodule

// ---- design/pldr_macro_ff.sv ----
/*
 * One configurable register of an output cell: D or T behaviour, own clock
 * term or pin clock, own reset term, shared synchronous preset.
 * Assumes all term inputs and the pin clock edge are on the pclk domain.
 */
`timescale 1ns/1ps
module pldr_macro_ff (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic hold,
  input  wire logic sum_term,
  input  wire logic clk_term,
  input  wire logic rst_term,
  input  wire logic preset_term,
  input  wire logic pin_edge,
  input  wire logic t_mode,
  input  wire logic pin_clk,
  output logic      q
);

  logic q_r;
  logic q_nxt;
  logic clk_prev_r;
  logic edge_hit;

  assign q = q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= clk_term;
    end
  end

  assign edge_hit = pin_clk ? pin_edge : (clk_term & ~clk_prev_r); // RQ2

  always_comb begin
    q_nxt = q_r;
    if (rst_term || hold) begin
      q_nxt = 1'b0; // RQ10 RQ17 RQ15
    end else if (edge_hit) begin
      if (preset_term) begin
        q_nxt = 1'b1; // RQ8
      end else if (t_mode) begin
        q_nxt = q_r ^ sum_term; // RQ1 RQ16
      end else begin
        q_nxt = sum_term; // RQ1
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule

// ---- design/pldr_top.sv ----
/*
 * Twenty-register output cell block with a small single-literal logic array,
 * configured over APB.
 * Assumes pins arrive asynchronously to pclk and the board resolves the I/O
 * wires from io_out and io_oe.
 */
// Implementation choices: the APB interface to the registers and the address map.
// Behaviour
// [RQ1] Each register is set by software as a D store or a T toggle.
// [RQ2] Each register is clocked by its own clock term or by the clock pin.
// [RQ3] Ten cells hold two registers each, twenty in all.
// [RQ4] Each register has its own data, reset and clock terms.
// [RQ5] Each I/O pin feeds the array over its own input path.
// [RQ6] Each register feeds its value back into the array on its own.
// [RQ7] Each I/O driver is enabled by its own term.
// [RQ8] One preset term, seen at a register's clock edge, sets that register.
// [RQ9] The board raises register clocks while preset is high, with setup.
// [RQ10] A high reset term clears its register without waiting for its clock.
// [RQ11] The board meets setup times before the first clock after power-up.
// [RQ12] The board keeps clocks still during the power-up interval.
// [RQ13] Legacy mode drops T behaviour and pin clocking.
// [RQ14] Once the security bit is set all configuration reads return ones.
// [RQ15] After power-up every register is low; pin level follows polarity.
// [RQ16] In T mode a high data term inverts and a low one holds.
// [RQ17] A reset term beats the preset term.
`timescale 1ns/1ps
module pldr_top (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [pldr_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [pldr_pkg::DATA_W-1:0]   pwdata,
  output logic      [pldr_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          clk_pin,
  input  wire logic [pldr_pkg::NUM_IN-1:0]   in_pin,
  input  wire logic [pldr_pkg::NUM_CELLS-1:0] io_in,
  output logic      [pldr_pkg::NUM_CELLS-1:0] io_out,
  output logic      [pldr_pkg::NUM_CELLS-1:0] io_oe
);

  localparam int NF = pldr_pkg::NUM_FF;
  localparam int NC = pldr_pkg::NUM_CELLS;
  localparam int NI = pldr_pkg::NUM_IN;
  localparam int DW = pldr_pkg::DATA_W;
  localparam int SW = pldr_pkg::SEL_W;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic          clk_s1_r;
  logic          clk_s2_r;
  logic          clk_s3_r;
  logic [NI-1:0] in_s1_r;
  logic [NI-1:0] in_s2_r;
  logic [NC-1:0] io_s1_r;
  logic [NC-1:0] io_s2_r;
  logic          pin_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
      in_s1_r  <= '0;
      in_s2_r  <= '0;
      io_s1_r  <= '0;
      io_s2_r  <= '0;
    end else begin
      clk_s1_r <= clk_pin;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      in_s1_r  <= in_pin;
      in_s2_r  <= in_s1_r;
      io_s1_r  <= io_in;
      io_s2_r  <= io_s1_r;
    end
  end

  // Pin clock is sampled, so pin clocks at or above half of pclk can be lost
  assign pin_edge = clk_s2_r & ~clk_s3_r;

  // ****************************************************************
  // Power-up hold
  // ****************************************************************
  pldr_pkg::pldr_por_t              por_r;
  logic [pldr_pkg::PUR_W-1:0]       por_cnt_r;
  logic                             hold;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_r     <= pldr_pkg::POR_HOLD;
      por_cnt_r <= '0;
    end else begin
      case (por_r)
        pldr_pkg::POR_HOLD: begin
          if (por_cnt_r == pldr_pkg::PUR_W'(pldr_pkg::PUR_CYCLES - 1)) begin
            por_r <= pldr_pkg::POR_RUN;
          end else begin
            por_cnt_r <= por_cnt_r + 1'b1;
          end
        end
        pldr_pkg::POR_RUN: begin
          por_r <= pldr_pkg::POR_RUN;
        end
        default: begin
          por_r <= pldr_pkg::POR_HOLD;
        end
      endcase
    end
  end

  assign hold = (por_r != pldr_pkg::POR_RUN); // RQ15

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [DW-1:0] ctrl_r;
  logic [DW-1:0] ff_cfg_r [NF];
  logic [DW-1:0] io_cfg_r [NC];
  logic          legacy;
  logic          fused;
  logic [NF-1:0] q;

  assign legacy = ctrl_r[pldr_pkg::CTRL_LEGACY_BIT];
  assign fused  = ctrl_r[pldr_pkg::CTRL_SECURE_BIT];

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic [pldr_pkg::ADDR_W-1:0] ff_off;
  logic [pldr_pkg::ADDR_W-1:0] io_off;
  logic [4:0]                  ff_idx;
  logic [3:0]                  io_idx;
  logic                        aligned;
  logic                        hit_ctrl;
  logic                        hit_status;
  logic                        hit_pins;
  logic                        hit_ff;
  logic                        hit_io;
  logic                        mapped;
  logic [DW-1:0]               rd_data;

  always_comb begin
    ff_off     = paddr - pldr_pkg::OFS_FF_BASE;
    io_off     = paddr - pldr_pkg::OFS_IO_BASE;
    ff_idx     = ff_off[pldr_pkg::FF_IDX_MSB:pldr_pkg::ADDR_LSB];
    io_idx     = io_off[pldr_pkg::IO_IDX_MSB:pldr_pkg::ADDR_LSB];
    aligned    = (paddr[pldr_pkg::ADDR_LSB-1:0] == '0);
    hit_ctrl   = aligned && (paddr == pldr_pkg::OFS_CTRL);
    hit_status = aligned && (paddr == pldr_pkg::OFS_STATUS);
    hit_pins   = aligned && (paddr == pldr_pkg::OFS_PINS);
    hit_ff     = aligned && (paddr >= pldr_pkg::OFS_FF_BASE)
                 && (paddr < pldr_pkg::OFS_FF_END);
    hit_io     = aligned && (paddr >= pldr_pkg::OFS_IO_BASE)
                 && (paddr < pldr_pkg::OFS_IO_END);
    mapped     = hit_ctrl | hit_status | hit_pins | hit_ff | hit_io;
    rd_data    = '0;
    if (hit_ctrl) begin
      rd_data = fused ? pldr_pkg::FUSED_READ : ctrl_r; // RQ14
    end else if (hit_status) begin
      rd_data = DW'(q);
    end else if (hit_pins) begin
      rd_data = DW'({io_s2_r, in_s2_r});
    end else if (hit_ff) begin
      rd_data = fused ? pldr_pkg::FUSED_READ : ff_cfg_r[ff_idx]; // RQ14
    end else if (hit_io) begin
      rd_data = fused ? pldr_pkg::FUSED_READ : io_cfg_r[io_idx]; // RQ14
    end
  end

  // Answer is prepared in the setup cycle, so every access has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_data : '0;
    end
  end

  logic wr_en;
  assign wr_en = psel & penable & pready & pwrite & mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= pldr_pkg::CTRL_RST;
    end else if (wr_en && hit_ctrl) begin
      ctrl_r <= (pwdata & pldr_pkg::CTRL_MASK)
                | (ctrl_r & (DW'(1) << pldr_pkg::CTRL_SECURE_BIT)); // RQ14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NF; i++) begin
        ff_cfg_r[i] <= pldr_pkg::FF_CFG_RST;
      end
    end else if (wr_en && hit_ff) begin
      ff_cfg_r[ff_idx] <= pwdata & pldr_pkg::FF_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int j = 0; j < NC; j++) begin
        io_cfg_r[j] <= pldr_pkg::IO_CFG_RST;
      end
    end else if (wr_en && hit_io) begin
      io_cfg_r[io_idx] <= pwdata & pldr_pkg::IO_MASK;
    end
  end

  // ****************************************************************
  // Logic array
  // ****************************************************************
  logic [pldr_pkg::ARR_W-1:0] arr;
  logic                       preset_term;

  // Pin inputs and feedbacks enter on separate positions
  always_comb begin
    arr = '0;
    arr[pldr_pkg::ARR_CLK] = clk_s2_r;
    arr[pldr_pkg::ARR_IN_LO +: NI] = in_s2_r;
    arr[pldr_pkg::ARR_IO_LO +: NC] = io_s2_r; // RQ5
    arr[pldr_pkg::ARR_FB_LO +: NF] = q; // RQ6
  end

  pldr_term u_preset (
    .arr  (arr),
    .sel  (ctrl_r[pldr_pkg::CTRL_PSEL_LSB +: SW]),
    .inv  (ctrl_r[pldr_pkg::CTRL_PINV_BIT]),
    .term (preset_term)
  );

  // ****************************************************************
  // Registers of the output cells
  // ****************************************************************
  for (genvar g = 0; g < NF; g++) begin : g_ff // RQ3
    logic sum_t;
    logic clk_t;
    logic rst_t;

    pldr_term u_sum (
      .arr  (arr),
      .sel  (ff_cfg_r[g][pldr_pkg::FF_DSEL_LSB +: SW]),
      .inv  (ff_cfg_r[g][pldr_pkg::FF_DINV_BIT]),
      .term (sum_t)
    ); // RQ4
    pldr_term u_clk (
      .arr  (arr),
      .sel  (ff_cfg_r[g][pldr_pkg::FF_CSEL_LSB +: SW]),
      .inv  (ff_cfg_r[g][pldr_pkg::FF_CINV_BIT]),
      .term (clk_t)
    ); // RQ4
    pldr_term u_rst (
      .arr  (arr),
      .sel  (ff_cfg_r[g][pldr_pkg::FF_RSEL_LSB +: SW]),
      .inv  (ff_cfg_r[g][pldr_pkg::FF_RINV_BIT]),
      .term (rst_t)
    ); // RQ4

    pldr_macro_ff u_ff (
      .pclk        (pclk),
      .presetn     (presetn),
      .hold        (hold),
      .sum_term    (sum_t),
      .clk_term    (clk_t),
      .rst_term    (rst_t),
      .preset_term (preset_term),
      .pin_edge    (pin_edge),
      .t_mode      (ff_cfg_r[g][pldr_pkg::FF_TMODE_BIT] & ~legacy), // RQ13
      .pin_clk     (ff_cfg_r[g][pldr_pkg::FF_PINCLK_BIT] & ~legacy), // RQ13
      .q           (q[g])
    );
  end

  // ****************************************************************
  // Output drivers
  // ****************************************************************
  logic [NC-1:0] oe_t;

  for (genvar c = 0; c < NC; c++) begin : g_io
    pldr_term u_oe (
      .arr  (arr),
      .sel  (io_cfg_r[c][pldr_pkg::IO_OSEL_LSB +: SW]),
      .inv  (io_cfg_r[c][pldr_pkg::IO_OINV_BIT]),
      .term (oe_t[c])
    ); // RQ7
  end

  // Register 0 of each cell drives the pin; register 1 is always buried
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_out <= '0;
      io_oe  <= '0;
    end else begin
      for (int k = 0; k < NC; k++) begin
        io_out[k] <= q[2*k] ^ io_cfg_r[k][pldr_pkg::IO_POL_BIT]; // RQ15
        io_oe[k]  <= oe_t[k]; // RQ7
      end
    end
  end

endmodule

// ---- dv/pldr_monitor.sv ----
/* Checker for the output cell block: bus timing, error decode, secure reads.
   Assumes it is bound to pldr_top and sees only its ports. */
`timescale 1ns/1ps
module pldr_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        clk_pin,
  input wire logic [10:0] in_pin,
  input wire logic [9:0]  io_in,
  input wire logic [9:0]  io_out,
  input wire logic [9:0]  io_oe
);
  // ********************
  // Helper state
  // ********************
  logic secure_r;
  logic cfg_seen_r;

  function automatic logic mapped(input logic [11:0] a);
    return a[1:0] == 2'b00 && (a < 12'h00C || (a >= 12'h040 && a < 12'h090)
      || (a >= 12'h100 && a < 12'h128));
  endfunction

  // Security is set-only, so a second reset is the one way back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secure_r   <= 1'b0;
      cfg_seen_r <= 1'b0;
    end else if (psel && penable && pready && pwrite) begin
      cfg_seen_r <= 1'b1;
      if (paddr == 12'h000 && pwdata[1]) begin
        secure_r <= 1'b1;
      end
    end
  end

  // ********************
  // Checks
  // ********************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup cycle");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without a setup cycle");
  err_decode_a: assert property (psel && !penable |=> pslverr == !mapped($past(paddr)))
    else $error("error flag does not match address decode");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer carries data");
  idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access cycle");
  secure_read_a: assert property (pready && !pwrite && secure_r && mapped(paddr)
    && paddr != 12'h004 && paddr != 12'h008 |-> prdata == 32'hFFFF_FFFF)
    else $error("configuration readable while secured");
  oe_quiet_a: assert property (io_oe != 10'h000 |-> cfg_seen_r)
    else $error("driver enabled before any configuration");
  out_quiet_a: assert property (io_out != 10'h000 |-> cfg_seen_r)
    else $error("output high before any configuration");

  cov_secure: cover property (pready && secure_r && paddr == 12'h040);
  cov_error: cover property (pslverr);
  cov_drive: cover property (io_oe[0] && io_out[0]);
endmodule

bind pldr_top pldr_monitor i_mon (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .clk_pin(clk_pin), .in_pin(in_pin), .io_in(io_in),
  .io_out(io_out), .io_oe(io_oe)
);

// ---- dv/pldr_board.sv ----
/* Board-side model driving the clock pin, input pins and I/O wires.
   Assumes the bench calls its tasks just after a rising pclk edge. */
`timescale 1ns/1ps
module pldr_board (
  input  wire logic        pclk,
  input  wire logic [9:0]  io_out,
  input  wire logic [9:0]  io_oe,
  output logic             clk_pin,
  output logic [10:0]      in_pin,
  output logic [9:0]       io_in
);
  // ********************
  // Pin drivers
  // ********************
  logic [9:0] drv_r;

  initial begin
    clk_pin = 1'b0;
    in_pin  = 11'h000;
    drv_r   = 10'h000;
  end

  // Block drives where enabled; the board drives the other wires from drv_r
  always_comb io_in = (io_oe & io_out) | (~io_oe & drv_r);

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Clocks stay still through the reset interval, then setup is met
  task automatic power_up();
    idle(pldr_pkg::PUR_CYCLES + 8);
  endtask

  // Levels, preset included, settle well before the next pulse
  task automatic set_in(input int idx, input logic v);
    @(posedge pclk);
    in_pin[idx] <= v;
    idle(6);
  endtask

  // Whole pin pattern; the board drives the wires that the block leaves free
  task automatic set_pins(input logic [10:0] iv, input logic [9:0] dv);
    @(posedge pclk);
    in_pin <= iv;
    drv_r  <= dv;
    idle(6);
  endtask

  // Four pclk high and six low, so the synchroniser cannot miss the edge
  task automatic pulse(input logic on_pin);
    @(posedge pclk);
    if (on_pin) clk_pin <= 1'b1;
    else in_pin[1] <= 1'b1;
    idle(4);
    if (on_pin) clk_pin <= 1'b0;
    else in_pin[1] <= 1'b0;
    idle(6);
  endtask
endmodule

// ---- dv/tb_top.sv ----
/* Self-checking bench for the output cell block.
   Assumes the board model drives the pins and the checker is bound. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) begin \
      err_total++; \
      $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_top;
  typedef struct {
    logic [11:0] addr;
    logic [31:0] data;
    logic        err;
  } pldr_row_t;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        clk_pin;
  logic [10:0] in_pin;
  logic [9:0]  io_in;
  logic [9:0]  io_out;
  logic [9:0]  io_oe;
  logic [31:0] rd;
  logic        er;
  int          err_total;
  int          check_count;
  pldr_row_t   rows [11];

  pldr_top i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_pin(clk_pin), .in_pin(in_pin), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));
  pldr_board i_board (.pclk(pclk), .io_out(io_out), .io_oe(io_oe),
    .clk_pin(clk_pin), .in_pin(in_pin), .io_in(io_in));

  // ********************
  // Tasks
  // ********************
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("read data", ex, rd)
  endtask

  // ********************
  // Sequence
  // ********************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    complete_run();
  end

  initial begin
    presetn = 1'b0;
    paddr   = 12'h000;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0000_0000;
    rows = '{'{12'h000, 32'h0000_3F00, 1'b0}, '{12'h004, 32'h0, 1'b0},
      '{12'h008, 32'h0, 1'b0}, '{12'h040, 32'h003F_3F00, 1'b0},
      '{12'h08C, 32'h003F_3F00, 1'b0}, '{12'h100, 32'h0000_003F, 1'b0},
      '{12'h124, 32'h0000_003F, 1'b0}, '{12'h00C, 32'h0, 1'b1},
      '{12'h090, 32'h0, 1'b1}, '{12'h128, 32'h0, 1'b1}, '{12'h041, 32'h0, 1'b1}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 32'h0000_0000);
      `CHK("row data", rows[i].data, rd)
      `CHK("row error", rows[i].err, er)
    end
    i_board.power_up();
    // D from pin, T with constant one, D from feedback, pin clocked
    apb(1'b1, 12'h040, 32'h003F_0201);
    apb(1'b1, 12'h044, 32'h013F_027F);
    apb(1'b1, 12'h048, 32'h003F_0216);
    apb(1'b1, 12'h04C, 32'h023F_3F7F);
    apb(1'b1, 12'h100, 32'h0000_007F);
    i_board.set_in(0, 1'b1);
    i_board.pulse(1'b0);
    rchk(12'h004, 32'h0000_0003);
    i_board.pulse(1'b0);
    rchk(12'h004, 32'h0000_0005);
    `CHK("io_out", 1'b1, io_out[0])
    `CHK("io_oe", 1'b1, io_oe[0])
    rchk(12'h008, 32'h0000_0801);
    // Upper inputs and free I/O wires reach the array; clock and reset pins stay put
    i_board.set_pins(11'h7F1, 10'h3FE);
    rchk(12'h008, 32'h001F_FFF1);
    apb(1'b1, 12'h104, 32'h0000_017F);
    rchk(12'h104, 32'h0000_017F);
    `CHK("io_out polarity", 1'b0, io_out[1])
    `CHK("io_oe term", 1'b1, io_oe[1])
    i_board.pulse(1'b1);
    rchk(12'h004, 32'h0000_000D);
    apb(1'b1, 12'h040, 32'h0003_0201);
    apb(1'b1, 12'h04C, 32'h0203_3F7F);
    apb(1'b1, 12'h000, 32'h0000_0400);
    i_board.set_in(2, 1'b1);
    rchk(12'h004, 32'h0000_0004);
    i_board.pulse(1'b0);
    rchk(12'h004, 32'h0000_0002);
    i_board.set_in(3, 1'b1);
    i_board.pulse(1'b0);
    rchk(12'h004, 32'h0000_0006);
    i_board.set_in(3, 1'b0);
    i_board.set_in(2, 1'b0);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    rchk(12'h004, 32'h0000_0006);
    apb(1'b1, 12'h000, 32'h0000_3F01);
    i_board.pulse(1'b1);
    i_board.pulse(1'b0);
    rchk(12'h004, 32'h0000_0003);
    apb(1'b1, 12'h000, 32'h0000_3F03);
    rchk(12'h040, 32'hFFFF_FFFF);
    rchk(12'h000, 32'hFFFF_FFFF);
    rchk(12'h004, 32'h0000_0003);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("io_oe in reset", 10'h000, io_oe)
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(12'h000, 32'h0000_3F00);
    rchk(12'h004, 32'h0000_0000);
    complete_run();
  end
endmodule
